// *** rtl/region_match.v ***
// Purpose: match one address against a bank of regions, pick lowest index hit
// Assumes: base aligned to region size by software
// Notes: size mode uses mask compare, limit mode uses range compare
`include "region_protect_map.vh"
module region_match #(
	parameter N = `RP_REGIONS,
	parameter AW = `RP_ADDR_W,
	parameter IW = `RP_IDX_W,
	parameter USE_LIMIT = 0,
	parameter MIN_SHIFT = `RP_MIN_SHIFT
) (
	input wire [AW-1:0] addr,
	input wire [N*AW-1:0] base_flat,
	input wire [N*(AW+1)-1:0] bound_flat,
	input wire [N-1:0] valid,
	output reg hit,
	output reg [IW-1:0] hit_idx
);
	wire [N-1:0] m;
	genvar g;
	generate
		for (g = 0; g < N; g = g + 1) begin : reg_cmp
			wire [AW-1:0] b = base_flat[g*AW +: AW];
			wire [AW:0] lim = bound_flat[g*(AW+1) +: AW+1];
			wire [AW-1:0] msk = lim[AW-1:0];
			wire [AW-MIN_SHIFT-1:0] hi_a = addr[AW-1:MIN_SHIFT];
			wire [AW-MIN_SHIFT-1:0] hi_b = b[AW-1:MIN_SHIFT];
			wire [AW-MIN_SHIFT-1:0] hi_m = msk[AW-1:MIN_SHIFT];
			// Low bits below minimum size never compared in size mode, saving logic
			if (USE_LIMIT != 0) begin : lim_mode
				assign m[g] = valid[g] && (addr >= b) && ({1'b0, addr} < lim); // (R8) (R9)
			end else begin : size_mode
				assign m[g] = valid[g] && ((hi_a & hi_m) == hi_b); // (R7) (R5) (R6)
			end
		end
	endgenerate
	integer i;
	always @* begin
		hit = 1'b0;
		hit_idx = {IW{1'b0}};
		// Descending scan so index zero wins
		for (i = N - 1; i >= 0; i = i - 1) begin
			if (m[i]) begin
				hit = 1'b1; // (R3)
				hit_idx = i[IW-1:0]; // (R2)
			end
		end
	end
endmodule

// *** rtl/region_protect_map.vh ***
// Purpose: constants for the region protection checker
// Assumes: 32-bit byte addresses, 40 MHz processor clock
// Notes: region counts and minimum size are also module parameters
`ifndef REGION_PROTECT_MAP_VH
`define REGION_PROTECT_MAP_VH
`define RP_REGIONS 32
`define RP_IDX_W 5
`define RP_ADDR_W 32
`define RP_MIN_SIZE 64
`define RP_MIN_SHIFT 6
`define RP_BYPASS_BIT 31
`define RP_PERM_X 0
`define RP_PERM_W 1
`define RP_PERM_R 0
`define RP_SEL_INST 1'b0
`define RP_SEL_DATA 1'b1
`define RP_PERM_W_BITS 2
`endif

// *** rtl/region_protect_unit.v ***
// Purpose: region memory protection checker for fetch and load/store stages
// Assumes: requests one-cycle, answers registered one cycle later
// Notes: region tables written through a simple config port
// Notes: verdicts are decoded combinationally and registered once
`include "region_protect_map.vh"
// Contract
// (R1) Holds thirty-two instruction and thirty-two data regions; fetches use instruction regions.
// (R2) Region index runs zero to count minus one; zero is highest priority.
// (R3) Lowest matching index alone decides permission and cacheability.
// (R4) Software aligns each base to region size; misalignment undefined.
// (R5) Build option chooses size or limit; sizes are powers of two.
// (R6) Minimum region 64 bytes, raisable by parameter; maximum is whole space.
// (R7) Size mode: address AND mask equals base means match.
// (R8) Limit mode: base <= address < limit means match.
// (R9) Limit field one bit wider than address.
// (R10) Address beyond reachable space matches nothing and faults.
// (R11) Execute for instruction regions, read/write for data; violation faults.
// (R12) No matching region of right type faults.
// (R13) Faults are precise; offending access is blocked from memory.
// (R14) Data regions carry default cacheability steering cache use.
// (R15) I/O loads and stores always bypass data cache.
// (R16) Address bit 31 bypass stays available.
// (R17) Disabled after reset, no checking until enabled.
// (R18) Enabled and disabled by software control register write.
// (R19) Software defines one region of each type before enabling.
// (R20) When enabled, every fetch and data access is checked.
// (R21) Per-mode permissions for user and supervisor.
// (R22) Status bit one selects user, zero supervisor.
// (R23) Disabled unit passes everything with no fault.
module region_protect_unit #(
	parameter N_INST = `RP_REGIONS,
	parameter N_DATA = `RP_REGIONS,
	parameter AW = `RP_ADDR_W,
	parameter IW = `RP_IDX_W,
	parameter USE_LIMIT = 0,
	parameter MIN_SHIFT = `RP_MIN_SHIFT,
	parameter [AW:0] SPACE_TOP = {1'b1, {AW{1'b0}}}
) (
	input wire clk,
	input wire rst,
	input wire ce,
	input wire ctl_wr,
	input wire ctl_enable,
	output wire enabled,
	input wire user_mode,
	input wire cfg_wr,
	input wire cfg_sel,
	input wire [IW-1:0] cfg_idx,
	input wire cfg_valid,
	input wire [AW-1:0] cfg_base,
	input wire [AW:0] cfg_bound,
	input wire [1:0] cfg_perm_user,
	input wire [1:0] cfg_perm_super,
	input wire cfg_cacheable,
	input wire fetch_req,
	input wire [AW-1:0] fetch_addr,
	output reg fetch_ok,
	output reg fetch_fault,
	output reg fetch_nomatch,
	input wire data_req,
	input wire data_wr,
	input wire data_io,
	input wire [AW-1:0] data_addr,
	output reg data_ok,
	output reg data_fault,
	output reg data_nomatch,
	output reg data_cached
);
	reg en_q;

	// Flat views of the region tables, one slice per entry
	wire [N_INST*AW-1:0] ibase;
	wire [N_INST*(AW+1)-1:0] ibound;
	wire [N_INST-1:0] ivalid;
	wire [N_INST-1:0] ix_user;
	wire [N_INST-1:0] ix_super;
	wire [N_DATA*AW-1:0] dbase;
	wire [N_DATA*(AW+1)-1:0] dbound;
	wire [N_DATA-1:0] dvalid;
	wire [N_DATA*2-1:0] drw_user;
	wire [N_DATA*2-1:0] drw_super;
	wire [N_DATA-1:0] dcache;
	wire ihit;
	wire dhit;
	wire [IW-1:0] iidx;
	wire [IW-1:0] didx;

	// Next-value verdicts, registered below
	reg fetch_ok_d;
	reg fetch_fault_d;
	reg fetch_nomatch_d;
	reg data_ok_d;
	reg data_fault_d;
	reg data_nomatch_d;
	reg data_cached_d;

	// Selected permissions of the winning entries
	reg x_perm;
	reg [1:0] rw_perm;
	genvar k;

	assign enabled = en_q;

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			en_q <= 1'b0; // (R17)
		end else if (ce && ctl_wr) begin
			en_q <= ctl_enable; // (R18)
		end
	end

	// One entry per index; valid bits clear at reset so stale entries never match
	generate
		for (k = 0; k < N_INST; k = k + 1) begin : inst_tab
			reg [AW-1:0] base_q;
			reg [AW:0] bound_q;
			reg valid_q;
			reg x_user_q;
			reg x_super_q;

			// Indices past the table size select no entry, so such writes drop
			wire pick = ce && cfg_wr && (cfg_sel == `RP_SEL_INST) && (cfg_idx == k); // (R1)
			assign ibase[k*AW +: AW] = base_q;
			assign ibound[k*(AW+1) +: AW+1] = bound_q;
			assign ivalid[k] = valid_q;
			assign ix_user[k] = x_user_q;
			assign ix_super[k] = x_super_q;

			always @(posedge clk or posedge rst) begin
				if (rst) begin
					base_q <= {AW{1'b0}};
					bound_q <= {(AW+1){1'b0}};
					valid_q <= 1'b0;
					x_user_q <= 1'b0;
					x_super_q <= 1'b0;
				end else if (pick) begin
					base_q <= cfg_base;
					bound_q <= cfg_bound; // (R9)
					valid_q <= cfg_valid;
					x_user_q <= cfg_perm_user[`RP_PERM_X]; // (R21)
					x_super_q <= cfg_perm_super[`RP_PERM_X];
				end
			end
		end
	endgenerate

	// Cacheability lives only in data entries
	generate
		for (k = 0; k < N_DATA; k = k + 1) begin : data_tab
			reg [AW-1:0] base_q;
			reg [AW:0] bound_q;
			reg valid_q;
			reg [1:0] rw_user_q;
			reg [1:0] rw_super_q;
			reg cache_q;

			wire pick = ce && cfg_wr && (cfg_sel == `RP_SEL_DATA) && (cfg_idx == k); // (R1)
			assign dbase[k*AW +: AW] = base_q;
			assign dbound[k*(AW+1) +: AW+1] = bound_q;
			assign dvalid[k] = valid_q;
			assign drw_user[k*2 +: 2] = rw_user_q;
			assign drw_super[k*2 +: 2] = rw_super_q;
			assign dcache[k] = cache_q;

			always @(posedge clk or posedge rst) begin
				if (rst) begin
					base_q <= {AW{1'b0}};
					bound_q <= {(AW+1){1'b0}};
					valid_q <= 1'b0;
					rw_user_q <= 2'h0;
					rw_super_q <= 2'h0;
					cache_q <= 1'b0;
				end else if (pick) begin
					base_q <= cfg_base;
					bound_q <= cfg_bound;
					valid_q <= cfg_valid;
					rw_user_q <= cfg_perm_user; // (R21)
					rw_super_q <= cfg_perm_super;
					cache_q <= cfg_cacheable; // (R14)
				end
			end
		end
	endgenerate

	region_match #(
		.N(N_INST),
		.AW(AW),
		.IW(IW),
		.USE_LIMIT(USE_LIMIT),
		.MIN_SHIFT(MIN_SHIFT)
	) u_inst (
		.addr(fetch_addr),
		.base_flat(ibase),
		.bound_flat(ibound),
		.valid(ivalid),
		.hit(ihit),
		.hit_idx(iidx)
	);

	region_match #(
		.N(N_DATA),
		.AW(AW),
		.IW(IW),
		.USE_LIMIT(USE_LIMIT),
		.MIN_SHIFT(MIN_SHIFT)
	) u_data (
		.addr(data_addr),
		.base_flat(dbase),
		.bound_flat(dbound),
		.valid(dvalid),
		.hit(dhit),
		.hit_idx(didx)
	);

	// Addresses past the connected space never match
	wire fetch_in_space = ({1'b0, fetch_addr} < SPACE_TOP);
	wire data_in_space = ({1'b0, data_addr} < SPACE_TOP);
	wire ihit_ok = ihit && fetch_in_space; // (R10)
	wire dhit_ok = dhit && data_in_space; // (R10)
	always @* begin
		x_perm = 1'b0;
		rw_perm = 2'h0;
		case (user_mode)
			1'b1: begin
				x_perm = ix_user[iidx]; // (R21) (R22)
				rw_perm = drw_user[didx*2 +: 2];
			end
			default: begin
				x_perm = ix_super[iidx];
				rw_perm = drw_super[didx*2 +: 2];
			end
		endcase
	end
	wire rw_allow = data_wr ? rw_perm[`RP_PERM_W] : rw_perm[`RP_PERM_R]; // (R11)

	// Address bit bypass keeps working with the checker enabled
	wire bit_bypass = data_addr[`RP_BYPASS_BIT]; // (R16)
	wire region_cached = dhit_ok ? dcache[didx] : 1'b0;
	wire data_bypass = data_io || bit_bypass; // (R15) (R16)

	// A faulted access never gets ok, so the pipeline never lets it reach memory
	always @* begin
		fetch_ok_d = 1'b0;
		fetch_fault_d = 1'b0;
		fetch_nomatch_d = 1'b0;

		if (fetch_req) begin
			if (!en_q) begin
				fetch_ok_d = 1'b1; // (R23)
			end else if (!ihit_ok) begin
				fetch_fault_d = 1'b1; // (R12) (R13) (R20)
				fetch_nomatch_d = 1'b1;
			end else if (!x_perm) begin
				fetch_fault_d = 1'b1; // (R11) (R13)
			end else begin
				fetch_ok_d = 1'b1;
			end
		end
	end

	always @* begin
		data_ok_d = 1'b0;
		data_fault_d = 1'b0;
		data_nomatch_d = 1'b0;
		data_cached_d = 1'b0;

		if (data_req) begin
			if (!en_q) begin
				data_ok_d = 1'b1; // (R23)
				data_cached_d = !data_bypass; // (R15) (R16)
			end else if (!dhit_ok) begin
				data_fault_d = 1'b1; // (R12) (R13) (R20)
				data_nomatch_d = 1'b1;
			end else if (!rw_allow) begin
				data_fault_d = 1'b1; // (R11) (R13)
			end else begin
				data_ok_d = 1'b1;
				data_cached_d = region_cached && !data_bypass; // (R14) (R15) (R16) (R3)
			end
		end
	end

	// One-cycle pulses; ce low holds them as they stand
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			fetch_ok <= 1'b0;
			fetch_fault <= 1'b0;
			fetch_nomatch <= 1'b0;
			data_ok <= 1'b0;
			data_fault <= 1'b0;
			data_nomatch <= 1'b0;
			data_cached <= 1'b0;
		end else if (ce) begin
			fetch_ok <= fetch_ok_d;
			fetch_fault <= fetch_fault_d;
			fetch_nomatch <= fetch_nomatch_d;
			data_ok <= data_ok_d;
			data_fault <= data_fault_d;
			data_nomatch <= data_nomatch_d;
			data_cached <= data_cached_d;
		end
	end
endmodule

// *** verification/issue_stage.sv ***
// Purpose: fetch and load/store issue stage facing the unit
// Assumes: go sampled on falling edge, request held one cycle
// Notes: idle address lines toggle so stale values never look valid
module issue_stage (
	input wire logic clk,
	input wire logic go,
	input wire logic is_data,
	input wire logic [31:0] addr,
	output logic fetch_req,
	output logic data_req,
	output logic [31:0] fetch_addr,
	output logic [31:0] data_addr
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		fetch_req = 1'b0;
		data_req = 1'b0;
		fetch_addr = 32'h0;
		data_addr = 32'h0;
	end
	always @(negedge clk) begin
		fetch_req <= go && !is_data;
		data_req <= go && is_data;
		fetch_addr <= (go && !is_data) ? addr : ~fetch_addr;
		data_addr <= (go && is_data) ? addr : ~data_addr;
	end
endmodule

// *** verification/rpu_checker.sv ***
// Purpose: port checks on the region protection unit
// Assumes: one clock, async active-high reset
// Notes: bound to every instance of the unit
module rpu_checker (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic ctl_wr,
	input wire logic ctl_enable,
	input wire logic enabled,
	input wire logic fetch_req,
	input wire logic fetch_ok,
	input wire logic fetch_fault,
	input wire logic fetch_nomatch,
	input wire logic data_req,
	input wire logic data_io,
	input wire logic [31:0] data_addr,
	input wire logic data_ok,
	input wire logic data_fault,
	input wire logic data_cached
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence fetch_taken;
		ce && fetch_req;
	endsequence
	reset_quiet_a: assert property ($fell(rst) |-> !enabled && !fetch_ok && !data_ok)
		else $error("outputs not idle after reset");
	enable_write_a: assert property (ce && ctl_wr |=> enabled == $past(ctl_enable))
		else $error("enable bit not written");
	fetch_answer_a: assert property (fetch_taken |=> fetch_ok != fetch_fault)
		else $error("fetch not answered");
	fetch_quiet_a: assert property (ce && !fetch_req |=> !fetch_ok && !fetch_fault)
		else $error("fetch answer without request");
	off_pass_a: assert property (ce && data_req && !enabled |=> data_ok && !data_fault)
		else $error("disabled unit faulted");
	io_bypass_a: assert property (ce && data_req && data_io |=> !data_cached)
		else $error("io access cached");
	bit31_bypass_a: assert property (ce && data_req && data_addr[31] |=> !data_cached)
		else $error("high address cached");
	nomatch_flag_a: assert property (fetch_nomatch |-> fetch_fault)
		else $error("nomatch without fault");
endmodule
bind region_protect_unit rpu_checker chk_u (.*);

// *** verification/tb_region_protect_unit.sv ***
// Purpose: self-checking bench for the region protection unit
// Assumes: size-mode build, default counts
// Notes: answers read one cycle after the request edge
module tb_region_protect_unit;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst = 1'b1, ce = 1'b1, ctl_wr = 1'b0, ctl_enable = 1'b0, user_mode = 1'b0;
	logic cfg_wr = 1'b0, cfg_sel = 1'b0, cfg_valid = 1'b0, cfg_cacheable = 1'b0, go = 1'b0, is_data = 1'b0;
	logic data_wr = 1'b0, data_io = 1'b0, enabled, fetch_req, fetch_ok, fetch_fault, fetch_nomatch;
	logic data_req, data_ok, data_fault, data_nomatch, data_cached;
	logic [4:0] cfg_idx = 5'h0;
	logic [1:0] cfg_perm_user = 2'h0, cfg_perm_super = 2'h0;
	logic [31:0] cfg_base = 32'h0, addr = 32'h0, fetch_addr, data_addr;
	logic [32:0] cfg_bound = 33'h0;
	int errors = 0, checks = 0;
	region_protect_unit dut_u (.*);
	issue_stage stage_u (.*);
	initial forever #12.5 clk = ~clk;
	task automatic end_sim;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic cmp(input logic [3:0] got, input logic [3:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cw(input logic s, input logic [4:0] i, input logic [31:0] b, input logic [31:0] m,
		input logic [1:0] pu, input logic [1:0] ps, input logic c);
		@(negedge clk);
		cfg_wr <= 1'b1;
		cfg_sel <= s;
		cfg_idx <= i;
		cfg_valid <= 1'b1;
		cfg_base <= b;
		cfg_bound <= {1'b0, m};
		cfg_perm_user <= pu;
		cfg_perm_super <= ps;
		cfg_cacheable <= c;
		@(negedge clk);
		cfg_wr <= 1'b0;
	endtask
	task automatic en(input logic v);
		@(negedge clk);
		ctl_wr <= 1'b1;
		ctl_enable <= v;
		@(negedge clk);
		ctl_wr <= 1'b0;
		cmp({3'h0, enabled}, {3'h0, v});
	endtask
	// Fault codes: {ok, fault, nomatch, cached}
	task automatic acc(input logic d, input logic w, input logic io, input logic u, input logic [31:0] a,
		input logic [3:0] e);
		@(negedge clk);
		go <= 1'b1;
		is_data <= d;
		data_wr <= w;
		data_io <= io;
		user_mode <= u;
		addr <= a;
		@(negedge clk);
		go <= 1'b0;
		@(negedge clk);
		if (d)
			cmp({data_ok, data_fault, data_nomatch, data_cached}, e);
		else
			cmp({fetch_ok, fetch_fault, fetch_nomatch, 1'b0}, e);
	endtask
	initial begin
		repeat (12) @(negedge clk);
		rst = 1'b0;
		cmp({3'h0, enabled}, 4'h0);
		acc(0, 0, 0, 1, 32'h0000_1010, 4'h8);
		acc(1, 1, 0, 1, 32'h0000_3000, 4'h9);
		cw(0, 5'h00, 32'h0000_1000, 32'hFFFF_F000, 2'h0, 2'h1, 0);
		cw(0, 5'h01, 32'h0000_0000, 32'h0000_0000, 2'h1, 2'h1, 0);
		cw(1, 5'h00, 32'h0000_2000, 32'hFFFF_FFC0, 2'h1, 2'h3, 1);
		cw(1, 5'h01, 32'h0000_4000, 32'hFFFF_C000, 2'h3, 2'h3, 0);
		en(1);
		acc(0, 0, 0, 0, 32'h0000_1010, 4'h8);
		acc(0, 0, 0, 1, 32'h0000_1010, 4'h4);
		acc(0, 0, 0, 1, 32'h0000_5000, 4'h8);
		acc(1, 1, 0, 0, 32'h0000_2004, 4'h9);
		acc(1, 1, 1, 0, 32'h0000_2004, 4'h8);
		acc(1, 1, 0, 1, 32'h0000_2004, 4'h4);
		acc(1, 0, 0, 1, 32'h0000_2004, 4'h9);
		acc(1, 0, 0, 0, 32'h0000_2040, 4'h6);
		acc(1, 0, 0, 1, 32'h0000_4100, 4'h8);
		acc(1, 0, 0, 0, 32'h0000_3000, 4'h6);
		en(0);
		acc(1, 0, 0, 0, 32'h8000_2000, 4'h8);
		acc(1, 1, 0, 1, 32'h0000_3000, 4'h9);
		@(negedge clk);
		ce <= 1'b0;
		acc(1, 0, 0, 0, 32'h0000_3000, 4'h0);
		ce <= 1'b1;
		end_sim();
	end
	initial begin
		#10000;
		errors++;
		end_sim();
	end
endmodule
